// ---- ddrc_ecc_if.sv ----
// Interface between the controller and its byte SECDED codec
`timescale 1ns/1ps
interface ddrc_ecc_if;
  logic [7:0] enc_data;
  logic [7:0] enc_check;
  logic [7:0] dec_data;
  logic [7:0] dec_check;
  logic [7:0] cor_data;
  logic single_err;
  logic double_err;
  modport ctrl (output enc_data, output dec_data, output dec_check,
                input enc_check, input cor_data, input single_err, input double_err);
  modport codec (input enc_data, input dec_data, input dec_check,
                 output enc_check, output cor_data, output single_err, output double_err);
endinterface : ddrc_ecc_if

// ---- ddrc_mem_model.sv ----
// Behavioural DDR memory answering reads with a strobe burst
`timescale 1ns/1ps
module ddrc_mem_model (
  input wire logic core_clk,
  input wire logic mem_cmd_valid,
  input wire logic mem_cmd_we,
  input wire logic [ddrc_pkg::MEM_AW-1:0] mem_addr,
  input wire logic [ddrc_pkg::DQ_W-1:0] mem_wdata,
  input wire logic [ddrc_pkg::DQ_W-1:0] flip,
  input wire logic mute,
  output logic mem_dqs,
  output logic [ddrc_pkg::DQ_W-1:0] mem_dq
);
  import ddrc_pkg::*;
  logic [DQ_W-1:0] mem [0:15];
  logic [DQ_W-1:0] w;
  // Store written words
  always @(posedge core_clk)
    if (mem_cmd_valid && mem_cmd_we)
      mem[mem_addr[3:0]] <= mem_wdata;
  // Strobe burst; data good only 40 to 80 ns after first edge
  initial
  begin
    mem_dqs = 1'b0;
    mem_dq = 16'hffff;
    forever
    begin
      @(posedge core_clk iff (mem_cmd_valid && !mem_cmd_we && !mute));
      w = mem[mem_addr[3:0]] ^ flip;
      #101 mem_dqs = 1'b1;
      mem_dq = ~w;
      #40 mem_dqs = 1'b0;
      mem_dq = w;
      #40 mem_dqs = 1'b1;
      mem_dq = ~w;
      #40 mem_dqs = 1'b0;
    end
  end
endmodule : ddrc_mem_model

// ---- ddrc_pkg.sv ----
// Shared constants and types for the DDR read calibration and ECC path
package ddrc_pkg;
  // Lane width selection values
  localparam logic LANE_ONE = 1'b0;
  localparam logic LANE_TWO = 1'b1;
  // Data path geometry
  localparam int BYTE_W = 8;
  localparam int LANES = 2;
  localparam int DQ_W = 16;
  localparam int BUS_AW = 30;
  localparam int MEM_AW = 29;
  localparam int MAP_TOP_BIT = 28;
  localparam int CHECK_W = 5;
  // Default width of each strobe read delay field
  localparam int DLY_W_DEF = 5;
  // Read strobe timeout
  localparam int CLK_PERIOD_NS = 4;
  localparam int RD_TIMEOUT_NS = 2000;
  localparam int RD_TIMEOUT_CYC = RD_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 9;
  // Reset values
  localparam logic [DQ_W-1:0] RST_DATA = 16'h0000;
  localparam logic [MEM_AW-1:0] RST_ADDR = 29'h0000000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_RD_WAIT = 4'h2,
    ST_RD_CAP = 4'h4,
    ST_RESP = 4'h8
  } ddrc_state_t;
endpackage : ddrc_pkg

// ---- ddrc_rdcal_ecc.sv ----
// DDR read window capture, ECC protection and bus memory map
//
// What this block does
// - Writes complete correctly; reads depend on calibrated strobe delay.
// - With ECC, correct single-bit and detect double-bit errors per byte.
// - With ECC, lane 1 holds check bits; only lower half visible.
// - Uncorrectable errors raise a bus error only when reporting enabled.
// - Corrected errors are signalled only when reporting enabled.
// - Up to 1 GB; large map bit opens space beyond 512 MB.
`timescale 1ns/1ps
module ddrc_rdcal_ecc #(
  parameter int DLY_W = ddrc_pkg::DLY_W_DEF
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic init_done,
  input wire logic lane_width_sel,
  input wire logic correction_enable,
  input wire logic uncorrectable_report_enable,
  input wire logic correctable_report_enable,
  input wire logic large_memory_map_enable,
  input wire logic [DLY_W-1:0] strobe_read_delay0,
  input wire logic [DLY_W-1:0] strobe_read_delay1,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [ddrc_pkg::BUS_AW-1:0] bus_addr,
  input wire logic [ddrc_pkg::DQ_W-1:0] bus_wdata,
  output logic bus_ready,
  output logic bus_ack,
  output logic [ddrc_pkg::DQ_W-1:0] bus_rdata,
  output logic bus_err,
  output logic bus_cor_evt,
  output logic mem_cmd_valid,
  output logic mem_cmd_we,
  output logic [ddrc_pkg::MEM_AW-1:0] mem_addr,
  output logic [ddrc_pkg::DQ_W-1:0] mem_wdata,
  input wire logic mem_dqs,
  input wire logic [ddrc_pkg::DQ_W-1:0] mem_dq
);
  import ddrc_pkg::*;

  ddrc_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic next_bus_ready, next_bus_ack, next_bus_err, next_bus_cor_evt;
  logic [DQ_W-1:0] next_bus_rdata, next_mem_wdata;
  logic next_mem_cmd_valid, next_mem_cmd_we;
  logic [MEM_AW-1:0] next_mem_addr;
  logic dqs_s1, dqs_s2, dqs_s3;
  logic [DQ_W-1:0] dq_s1, dq_s2;
  logic dqs_edge, accept, ecc_on, top_keep;
  logic [DLY_W-1:0] dly [LANES];
  logic [BYTE_W-1:0] lane [LANES];
  logic [BYTE_W-1:0] next_lane [LANES];
  logic [MEM_AW-1:0] word_addr;

  ddrc_ecc_if ecc_if ();

  // Byte codec
  ddrc_secded u_secded (
    .ecc (ecc_if.codec)
  );

  // Two-stage synchronisers for strobe and data pins
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      dqs_s1 <= 1'b0;
      dqs_s2 <= 1'b0;
      dqs_s3 <= 1'b0;
      dq_s1 <= RST_DATA;
      dq_s2 <= RST_DATA;
    end
    else
    begin
      dqs_s1 <= mem_dqs;
      dqs_s2 <= dqs_s1;
      dqs_s3 <= dqs_s2;
      dq_s1 <= mem_dq;
      dq_s2 <= dq_s1;
    end
  end

  // Strobe edges, both directions, request acceptance
  assign dqs_edge = dqs_s2 ^ dqs_s3;
  assign accept = bus_req && bus_ready;
  assign ecc_on = correction_enable;
  assign dly[0] = strobe_read_delay0;
  assign dly[1] = strobe_read_delay1;
  assign word_addr = bus_addr[BUS_AW-1:1];
  // ECC keeps software in lower half
  assign top_keep = word_addr[MAP_TOP_BIT] && large_memory_map_enable && !ecc_on;

  // Codec hookup
  assign ecc_if.enc_data = bus_wdata[BYTE_W-1:0];
  assign ecc_if.dec_data = lane[0];
  assign ecc_if.dec_check = lane[1];

  // Per-lane read capture at the programmed delay
  genvar l;
  generate
    for (l = 0; l < LANES; l++)
    begin : g_lane
      always_comb
      begin
        next_lane[l] = lane[l];
        if (state == ST_IDLE && accept && !bus_we)
          next_lane[l] = 8'h00;
        else if (state == ST_RD_CAP && cnt == CNT_W'(dly[l]) && (l == 0 || lane_width_sel == LANE_TWO))
          next_lane[l] = dq_s2[l*BYTE_W +: BYTE_W];
      end

      always_ff @(posedge core_clk)
      begin
        if (!resetn)
          lane[l] <= 8'h00;
        else
          lane[l] <= next_lane[l];
      end
    end
  endgenerate

  // Request sequencing and registered outputs
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_bus_ack = 1'b0;
    next_bus_err = 1'b0;
    next_bus_cor_evt = 1'b0;
    next_bus_rdata = bus_rdata;
    next_mem_cmd_valid = 1'b0;
    next_mem_cmd_we = mem_cmd_we;
    next_mem_addr = mem_addr;
    next_mem_wdata = mem_wdata;
    case (state)
      ST_IDLE:
      begin
        if (accept)
        begin
          next_mem_cmd_valid = 1'b1;
          next_mem_cmd_we = bus_we;
          next_mem_addr = {top_keep, word_addr[MAP_TOP_BIT-1:0]};
          next_cnt = '0;
          if (bus_we)
          begin
            next_bus_ack = 1'b1;
            next_mem_wdata = ecc_on ? {ecc_if.enc_check, bus_wdata[BYTE_W-1:0]} : bus_wdata;
          end
          else
            next_state = ST_RD_WAIT;
        end
      end
      ST_RD_WAIT:
      begin
        next_cnt = cnt + 1'b1;
        if (dqs_edge)
        begin
          next_state = ST_RD_CAP;
          next_cnt = '0;
        end
        else if (cnt == CNT_W'(RD_TIMEOUT_CYC - 1))
          next_state = ST_RESP;
      end
      ST_RD_CAP:
      begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'({DLY_W{1'b1}}))
          next_state = ST_RESP;
      end
      ST_RESP:
      begin
        next_state = ST_IDLE;
        next_bus_ack = 1'b1;
        if (ecc_on)
        begin
          next_bus_rdata = {8'h00, ecc_if.cor_data};
          next_bus_err = ecc_if.double_err && uncorrectable_report_enable;
          next_bus_cor_evt = ecc_if.single_err && correctable_report_enable;
        end
        else
          next_bus_rdata = {lane[1], lane[0]};
      end
      default:
        next_state = ST_IDLE;
    endcase
    next_bus_ready = init_done && next_state == ST_IDLE;
  end

  // State and output registers
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      state <= ST_IDLE;
      cnt <= '0;
      bus_ready <= 1'b0;
      bus_ack <= 1'b0;
      bus_err <= 1'b0;
      bus_cor_evt <= 1'b0;
      bus_rdata <= RST_DATA;
      mem_cmd_valid <= 1'b0;
      mem_cmd_we <= 1'b0;
      mem_addr <= RST_ADDR;
      mem_wdata <= RST_DATA;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      bus_ready <= next_bus_ready;
      bus_ack <= next_bus_ack;
      bus_err <= next_bus_err;
      bus_cor_evt <= next_bus_cor_evt;
      bus_rdata <= next_bus_rdata;
      mem_cmd_valid <= next_mem_cmd_valid;
      mem_cmd_we <= next_mem_cmd_we;
      mem_addr <= next_mem_addr;
      mem_wdata <= next_mem_wdata;
    end
  end

  // Checks on the block's own behaviour
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_wr_done;
    accept && bus_we |=> mem_cmd_valid && mem_cmd_we && bus_ack && bus_ready;
  endproperty
  a_wr_done: assert property (p_wr_done) else $error("write not issued next cycle");

  property p_correct;
    state == ST_RESP && ecc_on && ecc_if.single_err |=> bus_rdata[7:0] == $past(ecc_if.cor_data) && !bus_err;
  endproperty
  a_correct: assert property (p_correct) else $error("single error not corrected");

  property p_ecc_half;
    accept && correction_enable |=> !mem_addr[MAP_TOP_BIT];
  endproperty
  a_ecc_half: assert property (p_ecc_half) else $error("ECC access above lower half");

  property p_unc_gate;
    bus_err |-> bus_ack && $past(uncorrectable_report_enable) && $past(state == ST_RESP);
  endproperty
  a_unc_gate: assert property (p_unc_gate) else $error("bus error without enable");

  property p_cor_gate;
    bus_cor_evt |-> bus_ack && !bus_err && $past(correctable_report_enable, 1);
  endproperty
  a_cor_gate: assert property (p_cor_gate) else $error("corrected event without enable");

  property p_map;
    accept && !correction_enable |=>
      mem_addr[MAP_TOP_BIT] == ($past(bus_addr[MAP_TOP_BIT+1]) && $past(large_memory_map_enable));
  endproperty
  a_map: assert property (p_map) else $error("memory map top bit wrong");

  c_write: cover property (accept && bus_we ##1 bus_ack);
  c_read_cal: cover property (state == ST_RD_CAP ##[1:40] bus_ack);
  c_corrected: cover property (bus_cor_evt);
  c_uncorrectable: cover property (bus_err);
endmodule : ddrc_rdcal_ecc

// ---- ddrc_secded.sv ----
// Single-correct double-detect codec for one data byte
`timescale 1ns/1ps
module ddrc_secded (
  ddrc_ecc_if.codec ecc
);
  import ddrc_pkg::*;

  // Hamming position of each data bit
  localparam logic [3:0] DPOS [8] = '{4'h3, 4'h5, 4'h6, 4'h7, 4'h9, 4'ha, 4'hb, 4'hc};

  // Syndrome over a 12-bit code word, positions 1 to 12
  function automatic logic [3:0] ddrc_syn(input logic [7:0] d, input logic [3:0] p);
    logic [3:0] s;
    s = p;
    for (int i = 0; i < 8; i++)
    begin
      if (d[i])
        s = s ^ DPOS[i];
    end
    return s;
  endfunction : ddrc_syn

  logic [3:0] enc_p;
  logic [3:0] syn;
  logic ovr_err;
  logic [7:0] flip;

  // Encode: check bits plus overall parity
  assign enc_p = ddrc_syn(ecc.enc_data, 4'h0);
  assign ecc.enc_check = {3'h0, ^{ecc.enc_data, enc_p}, enc_p};

  // Decode syndrome and overall parity
  assign syn = ddrc_syn(ecc.dec_data, ecc.dec_check[3:0]);
  assign ovr_err = ^{ecc.dec_data, ecc.dec_check[CHECK_W-1:0]};

  // Flip the data bit that the syndrome points at
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_flip
      assign flip[g] = ovr_err && (syn == DPOS[g]);
    end
  endgenerate

  assign ecc.cor_data = ecc.dec_data ^ flip;
  assign ecc.single_err = ovr_err;
  assign ecc.double_err = !ovr_err && (syn != 4'h0);
endmodule : ddrc_secded

// ---- tb.sv ----
// Self-checking bench for read calibration, ECC and memory map
`timescale 1ns/1ps
module tb;
  import ddrc_pkg::*;
  typedef struct packed {logic c; logic e; logic [15:0] f; logic x_err; logic x_cor;} ddrc_row_t;
  logic core_clk = 1'b0, resetn = 1'b0, init_done = 1'b1, lane_width_sel = 1'b0, correction_enable = 1'b0;
  logic unc_en = 1'b0, cor_en = 1'b0, big = 1'b0, bus_req = 1'b0, bus_we = 1'b0, mute = 1'b0;
  logic [4:0] dly0 = 5'h00, dly1 = 5'h00;
  logic [29:0] bus_addr = 30'h0;
  logic [15:0] bus_wdata = 16'h0, flip = 16'h0, r_data, bus_rdata, mem_wdata, mem_dq;
  logic bus_ready, bus_ack, bus_err, bus_cor_evt, mem_cmd_valid, mem_cmd_we, mem_dqs, r_err, r_cor;
  logic [28:0] mem_addr;
  int bad_count = 0, total_checks = 0;
  ddrc_row_t rows [7] = '{'{0, 0, 16'h0, 0, 0}, '{1, 1, 16'h0, 0, 0}, '{1, 0, 16'h4, 0, 1},
    '{0, 1, 16'h4, 0, 0}, '{1, 1, 16'h100, 0, 1}, '{1, 1, 16'h12, 1, 0}, '{1, 0, 16'h12, 0, 0}};
  // Core clock, 4 ns period
  always #2 core_clk = ~core_clk;
  ddrc_rdcal_ecc #(.DLY_W(5)) u_dut (.core_clk, .resetn, .init_done, .lane_width_sel, .correction_enable,
    .uncorrectable_report_enable(unc_en), .correctable_report_enable(cor_en), .large_memory_map_enable(big),
    .strobe_read_delay0(dly0), .strobe_read_delay1(dly1), .bus_req, .bus_we, .bus_addr, .bus_wdata, .bus_ready,
    .bus_ack, .bus_rdata, .bus_err, .bus_cor_evt, .mem_cmd_valid, .mem_cmd_we, .mem_addr, .mem_wdata,
    .mem_dqs, .mem_dq);
  ddrc_mem_model u_mem (.core_clk, .mem_cmd_valid, .mem_cmd_we, .mem_addr, .mem_wdata, .flip, .mute,
    .mem_dqs, .mem_dq);

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic hang(input string what);
    bad_count++;
    $display("BAD %0t %s", $time, what);
    wrap_up();
  endtask : hang

  task automatic chk(input logic [16:0] got, input logic [16:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk

  // Bus cycle, entered and left on a rising edge
  task automatic bus_op(input logic we, input logic [29:0] a, input logic [15:0] d);
    int n;
    bus_req <= 1'b1;
    bus_we <= we;
    bus_addr <= a;
    bus_wdata <= d;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (bus_ready !== 1'b1 && n < 50);
    if (bus_ready !== 1'b1)
      hang("never ready");
    bus_req <= 1'b0;
    #1;
    for (n = 0; bus_ack !== 1'b1 && n < 700; n++)
    begin
      @(posedge core_clk);
      #1;
    end
    if (n == 700)
      hang("no ack");
    r_data = bus_rdata;
    r_err = bus_err;
    r_cor = bus_cor_evt;
    @(posedge core_clk);
  endtask : bus_op

  // Host calibration of the strobe read delays
  task automatic cal(input logic two);
    logic [7:0] want;
    logic s0;
    logic s1;
    lane_width_sel <= two;
    bus_op(1'b1, 30'h20000000, two ? 16'hffff : 16'h00ff);
    if (two)
      bus_op(1'b1, 30'h20000004, 16'h0000);
    dly0 <= 5'h00;
    dly1 <= 5'h00;
    for (int ph = 0; ph < 2; ph++)
    begin
      want = ph ? 8'h00 : 8'hff;
      do
      begin
        bus_op(1'b0, 30'h20000000, 16'h0000);
        s0 = r_data[7:0] !== want;
        s1 = two && r_data[15:8] !== want;
        if ((s0 && dly0 == 5'h1f) || (s1 && dly1 == 5'h1f))
          hang("delay limit");
        if (s0)
          dly0 <= dly0 + 5'h01;
        if (s1)
          dly1 <= dly1 + 5'h01;
      end while (s0 || s1);
    end
    dly0 <= dly0 - 5'h03;
    if (two)
      dly1 <= dly1 - 5'h03;
    bus_op(1'b0, 30'h20000000, 16'h0000);
    chk(r_data, two ? 16'hffff : 16'h00ff, "calibrated read");
    $display("test cal lanes %0d done", two + 1);
  endtask : cal

  // Main sequence
  initial
  begin
    repeat (19) @(posedge core_clk);
    #1 chk({bus_ready, bus_ack, mem_cmd_valid}, 3'h0, "reset outputs");
    @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    cal(1'b0);
    cal(1'b1);
    bus_op(1'b1, 30'h20000008, 16'h5a3c);
    bus_op(1'b0, 30'h20000008, 16'h0000);
    chk(r_data, 16'h5a3c, "word after cal");
    correction_enable <= 1'b1;
    bus_op(1'b1, 30'h20000010, 16'h77a5);
    chk(mem_wdata, 16'h03a5, "data and check lanes");
    foreach (rows[i])
    begin
      cor_en <= rows[i].c;
      unc_en <= rows[i].e;
      flip <= rows[i].f;
      bus_op(1'b0, 30'h20000010, 16'h0000);
      if ($countones(rows[i].f) < 2)
        chk(r_data, 16'h00a5, "ecc data");
      chk({r_err, r_cor}, {rows[i].x_err, rows[i].x_cor}, "ecc flags");
    end
    flip <= 16'h0;
    $display("test ecc rows done");
    for (int m = 0; m < 3; m++)
    begin
      big <= m != 0;
      correction_enable <= m == 2;
      bus_op(1'b1, 30'h20000000, 16'h00ff);
      chk(mem_addr[28], m == 1, "map bit");
    end
    $display("test map done");
    mute <= 1'b1;
    bus_op(1'b0, 30'h20000000, 16'h0000);
    chk({r_data, r_err}, 17'h0, "timeout read");
    mute <= 1'b0;
    $display("test timeout done");
    init_done <= 1'b0;
    repeat (2) @(posedge core_clk);
    bus_req <= 1'b1;
    bus_we <= 1'b1;
    repeat (6)
    begin
      @(posedge core_clk);
      #1 chk(mem_cmd_valid, 1'b0, "cmd while not ready");
    end
    @(posedge core_clk);
    bus_req <= 1'b0;
    init_done <= 1'b1;
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1 chk({bus_ready, bus_ack, bus_err, mem_cmd_valid}, 4'h0, "outputs in reset");
    @(posedge core_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1 chk(bus_ready, 1'b1, "ready after reset");
    $display("test refuse and reset done");
    wrap_up();
  end
endmodule : tb
